// *** include/flash_host_pkg.sv ***
// Constants, command codes and register map of the parallel flash host.
// Assumes a 40 MHz clock and a word-wide flash with 19 address lines.
package flash_host_pkg;
   // Widths
   localparam int ADDR_W = 19;
   localparam int DATA_W = 16;
   localparam int SYNC_STAGES = 2;
   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_ACCESS_NS = 90;
   localparam int T_WRITE_PULSE_NS = 50;
   localparam int ACC_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WP_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] READ_LEN = 4'(ACC_CYC + SYNC_STAGES - 1);
   localparam logic [3:0] WRITE_LEN = 4'(WP_CYC - 1);
   // Coded cycles
   localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 19'h05555;
   localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 19'h02aaa;
   localparam logic [DATA_W-1:0] CODE_UNLOCK1 = 16'h00aa;
   localparam logic [DATA_W-1:0] CODE_UNLOCK2 = 16'h0055;
   localparam logic [DATA_W-1:0] CODE_SETUP_ERASE = 16'h0080;
   localparam logic [DATA_W-1:0] CODE_SIGNATURE = 16'h0090;
   localparam logic [DATA_W-1:0] CODE_PROGRAM = 16'h00a0;
   localparam logic [DATA_W-1:0] CODE_PAUSE = 16'h00b0;
   localparam logic [DATA_W-1:0] CODE_BLOCK_CONF = 16'h0030;
   localparam logic [DATA_W-1:0] CODE_CHIP_CONF = 16'h0010;
   localparam logic [DATA_W-1:0] CODE_READ_ARRAY = 16'h00f0;
   // Status byte of the flash
   localparam int POLLING_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int FAILURE_BIT = 5;
   localparam int TIMEOUT_WINDOW_BIT = 3;
   localparam int ALT_TOGGLE_BIT = 2;
   localparam logic [7:0] STATUS_MASK = 8'hec;
   // Software registers
   localparam logic [2:0] REG_CMD = 3'h0;
   localparam logic [2:0] REG_ADDR = 3'h1;
   localparam logic [2:0] REG_DATA = 3'h2;
   localparam logic [2:0] REG_STATUS = 3'h3;
   localparam logic [2:0] REG_RDATA = 3'h4;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_ERROR = 2;
   localparam int ST_READY = 3;
   localparam int ST_FLAGS_LSB = 8;

   typedef enum logic [2:0] {
      OP_READ_ARRAY = 3'h0,
      OP_SIGNATURE = 3'h1,
      OP_READ = 3'h2,
      OP_WORD_WRITE = 3'h3,
      OP_SECTOR_WIPE = 3'h4,
      OP_CHIP_WIPE = 3'h5,
      OP_WIPE_PAUSE = 3'h6,
      OP_WIPE_CONTINUE = 3'h7
   } op_type;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_WRITE = 3'h1,
      S_READ = 3'h2,
      S_POLL = 3'h3,
      S_FINAL = 3'h4
   } seq_state_type;

   typedef enum logic [1:0] {
      CY_IDLE = 2'h0,
      CY_SETUP = 2'h1,
      CY_STROBE = 2'h2,
      CY_HOLD = 2'h3
   } cyc_state_type;
endpackage

// *** logic/flash_bus_cycle.sv ***
// One asynchronous read or write cycle on the flash pins.
// Assumes the flash answers within the access time; data pins are synchronised here.
`timescale 1ns/1ps
module flash_bus_cycle #(
   parameter int ADDR_W = flash_host_pkg::ADDR_W,
   parameter int DATA_W = flash_host_pkg::DATA_W
) (
   // Clock, reset and enable
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_ce,
   // Request
   input wire logic i_start,
   input wire logic i_write,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   output logic o_done,
   output logic [DATA_W-1:0] o_rdata,
   // Flash pins
   output logic o_chip_sel_n,
   output logic o_out_en_n,
   output logic o_write_n,
   output logic [ADDR_W-1:0] o_addr,
   output logic [DATA_W-1:0] o_dq,
   output logic o_dq_oe_n,
   input wire logic [DATA_W-1:0] i_dq
);
   import flash_host_pkg::*;

   cyc_state_type state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic write_r;
   logic [DATA_W-1:0] dq_meta_r, dq_sync_r;

   wire take = (state_r == CY_IDLE) && i_start;
   wire write_nxt = take ? i_write : write_r;
   wire strobe_end = (state_r == CY_STROBE) && (cnt_r == 4'h0);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      unique case (state_r)
         CY_IDLE: if (i_start) state_nxt = CY_SETUP;
         CY_SETUP: begin
            state_nxt = CY_STROBE;
            cnt_nxt = write_r ? WRITE_LEN : READ_LEN;
         end
         CY_STROBE: begin
            if (cnt_r == 4'h0) state_nxt = CY_HOLD;
            else cnt_nxt = cnt_r - 4'h1;
         end
         CY_HOLD: state_nxt = CY_IDLE;
      endcase
   end

   // Data pins cross from outside, so two flops before use
   always_ff @(posedge i_mclk) begin
      dq_meta_r <= i_dq;
      dq_sync_r <= dq_meta_r;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         state_r <= CY_IDLE;
         cnt_r <= 4'h0;
         write_r <= 1'b0;
         o_done <= 1'b0;
         o_chip_sel_n <= 1'b1;
         o_out_en_n <= 1'b1;
         o_write_n <= 1'b1;
         o_dq_oe_n <= 1'b1;
      end else if (i_ce) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         write_r <= write_nxt;
         o_done <= (state_r == CY_HOLD);
         o_chip_sel_n <= (state_nxt == CY_IDLE);
         // Strobe released between reads so each one is a fresh read
         o_out_en_n <= !((state_nxt == CY_STROBE) && !write_nxt);
         o_write_n <= !((state_nxt == CY_STROBE) && write_nxt);
         o_dq_oe_n <= !((state_nxt != CY_IDLE) && write_nxt);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         o_addr <= '0;
         o_dq <= '0;
         o_rdata <= '0;
      end else if (i_ce) begin
         if (take) begin
            o_addr <= i_addr;
            o_dq <= i_wdata;
         end
         if (strobe_end && !write_r) o_rdata <= dq_sync_r;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);

   a_strobe_excl: assert property (!(!o_write_n && !o_out_en_n))
      else $error("write and output strobes low together");
   a_drive_write: assert property (!o_write_n |-> !o_dq_oe_n && !o_chip_sel_n)
      else $error("write strobe without data drive");
   a_no_drive_read: assert property (!o_out_en_n |-> o_dq_oe_n)
      else $error("data driven during a read");
endmodule

// *** logic/flash_host_ctrl.sv ***
// Host controller issuing coded instruction sequences to a parallel flash.
// Assumes a software port with one-cycle strobes and a word-wide flash.
//
// Contract
// - Instructions span one to six bus cycles
// - Host writes each sequence in order, uninterrupted
// - Multi-cycle instructions start with unlock pair
// - Erase confirm preceded by second unlock pair
// - Host masks reserved status bits 0,1,4
// - Poll at programmed address or erased block
// - Two equal toggle reads mean done; reread
// - Sector wipe ends with 30h at block
// - Host polls status until wipe completes
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module flash_host_ctrl #(
   parameter int ADDR_W = flash_host_pkg::ADDR_W,
   parameter int DATA_W = flash_host_pkg::DATA_W
) (
   // Clock, reset, enable
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_ce,
   // Software port
   input wire logic [2:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   // Flash pins
   output logic o_chip_sel_n,
   output logic o_out_en_n,
   output logic o_write_n,
   output logic [ADDR_W-1:0] o_addr,
   output logic [DATA_W-1:0] o_dq,
   output logic o_dq_oe_n,
   input wire logic [DATA_W-1:0] i_dq,
   input wire logic i_ready_busy
);
   import flash_host_pkg::*;

   seq_state_type state_r, state_nxt;
   op_type op_r, op_nxt;
   logic [2:0] step_r, step_nxt;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] data_r, rdata_r, rdata_nxt;
   logic [7:0] prev_r, prev_nxt, flags_r, flags_nxt;
   logic busy_r, busy_nxt, done_r, done_nxt, err_r, err_nxt;
   logic wait_r, wait_nxt, go_r, go_nxt, first_r, first_nxt, fail_r, fail_nxt;
   logic rb_meta_r, rb_sync_r;
   logic cyc_done;
   logic [DATA_W-1:0] cyc_rdata;

   function automatic logic [2:0] writes_of(input op_type op);
      unique case (op)
         OP_READ: writes_of = 3'd0;
         OP_SIGNATURE: writes_of = 3'd3;
         OP_WORD_WRITE: writes_of = 3'd4;
         OP_SECTOR_WIPE, OP_CHIP_WIPE: writes_of = 3'd6;
         OP_READ_ARRAY, OP_WIPE_PAUSE, OP_WIPE_CONTINUE: writes_of = 3'd1;
      endcase
   endfunction

   function automatic logic single_op(input op_type op);
      single_op = (op == OP_READ_ARRAY) || (op == OP_WIPE_PAUSE) || (op == OP_WIPE_CONTINUE);
   endfunction

   function automatic logic [DATA_W-1:0] code_of(input op_type op, input logic [2:0] step,
                                                 input logic [DATA_W-1:0] wdata);
      code_of = CODE_UNLOCK1;
      unique case (step)
         3'd0: begin
            if (op == OP_READ_ARRAY) code_of = CODE_READ_ARRAY;
            else if (op == OP_WIPE_PAUSE) code_of = CODE_PAUSE;
            else if (op == OP_WIPE_CONTINUE) code_of = CODE_BLOCK_CONF;
         end
         3'd1, 3'd4: code_of = CODE_UNLOCK2;
         3'd2: begin
            if (op == OP_SIGNATURE) code_of = CODE_SIGNATURE;
            else if (op == OP_WORD_WRITE) code_of = CODE_PROGRAM;
            else code_of = CODE_SETUP_ERASE;
         end
         3'd3: if (op == OP_WORD_WRITE) code_of = wdata;
         3'd5: code_of = (op == OP_SECTOR_WIPE) ? CODE_BLOCK_CONF : CODE_CHIP_CONF;
         default: code_of = CODE_UNLOCK1;
      endcase
   endfunction

   function automatic logic [ADDR_W-1:0] addr_of(input op_type op, input logic [2:0] step,
                                                 input logic [ADDR_W-1:0] target);
      addr_of = UNLOCK_ADDR1;
      unique case (step)
         3'd0: if (single_op(op)) addr_of = target;
         3'd1, 3'd4: addr_of = UNLOCK_ADDR2;
         3'd3: if (op == OP_WORD_WRITE) addr_of = target;
         3'd5: if (op == OP_SECTOR_WIPE) addr_of = target;
         default: addr_of = UNLOCK_ADDR1;
      endcase
   endfunction

   // Decode
   wire cmd_wr = i_reg_wr && (i_reg_addr == REG_CMD) && !busy_r;
   wire addr_wr = i_reg_wr && (i_reg_addr == REG_ADDR) && !busy_r;
   wire data_wr = i_reg_wr && (i_reg_addr == REG_DATA) && !busy_r;
   wire op_type op_req = op_type'(i_reg_wdata[2:0]);
   wire last_write = (step_r == writes_of(op_r) - 3'd1);
   wire poll_op = (op_r == OP_WORD_WRITE) || (op_r == OP_SECTOR_WIPE) || (op_r == OP_CHIP_WIPE)
                  || (op_r == OP_WIPE_CONTINUE);
   wire read_op = (op_r == OP_SIGNATURE) || (op_r == OP_READ);
   wire cyc_write = (state_r == S_WRITE);
   // Writes follow the table; polls stay on the target address
   wire [ADDR_W-1:0] cyc_addr = cyc_write ? addr_of(op_r, step_r, addr_r) : addr_r;
   wire [DATA_W-1:0] cyc_wdata = code_of(op_r, step_r, data_r);
   wire [7:0] rd_byte = cyc_rdata[7:0];
   wire toggle_same = (prev_r[TOGGLE_BIT] == rd_byte[TOGGLE_BIT]);
   wire [31:0] status_word = {16'h0000, flags_r, 4'h0, rb_sync_r, err_r, done_r, busy_r};
   wire [31:0] read_mux = (i_reg_addr == REG_CMD) ? {29'h0, op_r} :
                          (i_reg_addr == REG_ADDR) ? 32'(addr_r) :
                          (i_reg_addr == REG_DATA) ? 32'(data_r) :
                          (i_reg_addr == REG_STATUS) ? status_word :
                          (i_reg_addr == REG_RDATA) ? 32'(rdata_r) : 32'h0000_0000;

   always_comb begin
      state_nxt = state_r;
      op_nxt = op_r;
      step_nxt = step_r;
      rdata_nxt = rdata_r;
      prev_nxt = prev_r;
      flags_nxt = flags_r;
      busy_nxt = busy_r;
      done_nxt = done_r;
      err_nxt = err_r;
      first_nxt = first_r;
      fail_nxt = fail_r;
      go_nxt = 1'b0;
      wait_nxt = wait_r;
      if (state_r != S_IDLE && !wait_r) begin
         go_nxt = 1'b1;
         wait_nxt = 1'b1;
      end
      if (cyc_done) wait_nxt = 1'b0;
      unique case (state_r)
         S_IDLE: if (cmd_wr) begin
            op_nxt = op_req;
            step_nxt = 3'd0;
            busy_nxt = 1'b1;
            done_nxt = 1'b0;
            err_nxt = 1'b0;
            first_nxt = 1'b1;
            fail_nxt = 1'b0;
            state_nxt = (op_req == OP_READ) ? S_READ : S_WRITE;
         end
         // One sequence runs to its end before any other write
         S_WRITE: if (cyc_done) begin
            if (!last_write) step_nxt = step_r + 3'd1;
            else if (poll_op) state_nxt = S_POLL;
            else if (read_op) state_nxt = S_READ;
            else begin
               state_nxt = S_IDLE;
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
            end
         end
         S_POLL: if (cyc_done) begin
            flags_nxt = rd_byte & STATUS_MASK;
            prev_nxt = rd_byte;
            first_nxt = 1'b0;
            if (!first_r && toggle_same) state_nxt = S_FINAL;
            else if (!first_r && fail_r) begin
               state_nxt = S_IDLE;
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
               err_nxt = 1'b1;
            end else if (!first_r) fail_nxt = rd_byte[FAILURE_BIT];
         end
         S_READ, S_FINAL: if (cyc_done) begin
            rdata_nxt = cyc_rdata;
            state_nxt = S_IDLE;
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end
         default: state_nxt = S_IDLE;
      endcase
   end

   // Ready/busy pin from outside: two flops before use
   always_ff @(posedge i_mclk) begin
      rb_meta_r <= i_ready_busy;
      rb_sync_r <= rb_meta_r;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         state_r <= S_IDLE;
         op_r <= OP_READ_ARRAY;
         step_r <= 3'd0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         err_r <= 1'b0;
         first_r <= 1'b0;
         fail_r <= 1'b0;
         wait_r <= 1'b0;
         go_r <= 1'b0;
      end else if (i_ce) begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         step_r <= step_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         err_r <= err_nxt;
         first_r <= first_nxt;
         fail_r <= fail_nxt;
         wait_r <= wait_nxt;
         go_r <= go_nxt;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         addr_r <= '0;
         data_r <= '0;
         rdata_r <= '0;
         prev_r <= 8'h00;
         flags_r <= 8'h00;
         o_reg_rdata <= 32'h0000_0000;
      end else if (i_ce) begin
         if (addr_wr) addr_r <= i_reg_wdata[ADDR_W-1:0];
         if (data_wr) data_r <= i_reg_wdata[DATA_W-1:0];
         rdata_r <= rdata_nxt;
         prev_r <= prev_nxt;
         flags_r <= flags_nxt;
         o_reg_rdata <= i_reg_rd ? read_mux : 32'h0000_0000;
      end
   end

   flash_bus_cycle #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_cycle (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_ce(i_ce),
      .i_start(go_r),
      .i_write(cyc_write),
      .i_addr(cyc_addr),
      .i_wdata(cyc_wdata),
      .o_done(cyc_done),
      .o_rdata(cyc_rdata),
      .o_chip_sel_n(o_chip_sel_n),
      .o_out_en_n(o_out_en_n),
      .o_write_n(o_write_n),
      .o_addr(o_addr),
      .o_dq(o_dq),
      .o_dq_oe_n(o_dq_oe_n),
      .i_dq(i_dq)
   );

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);

   a_step_bound: assert property (state_r == S_WRITE |-> step_r < 3'd6)
      else $error("sequence longer than six writes");
   a_unlock_one: assert property (go_r && cyc_write && step_r == 3'd0 && !single_op(op_r)
      |-> cyc_addr == UNLOCK_ADDR1 && cyc_wdata == CODE_UNLOCK1)
      else $error("first unlock cycle wrong");
   a_unlock_two: assert property (go_r && cyc_write && step_r == 3'd1
      |-> cyc_addr == UNLOCK_ADDR2 && cyc_wdata == CODE_UNLOCK2)
      else $error("second unlock cycle wrong");
   a_erase_relock: assert property (go_r && cyc_write && (op_r == OP_SECTOR_WIPE || op_r == OP_CHIP_WIPE)
      && step_r == 3'd4 |-> cyc_addr == UNLOCK_ADDR2 && cyc_wdata == CODE_UNLOCK2)
      else $error("erase second unlock pair wrong");
   a_prog_fourth: assert property (go_r && cyc_write && op_r == OP_WORD_WRITE && step_r == 3'd3
      |-> cyc_addr == addr_r && cyc_wdata == data_r)
      else $error("program fourth cycle wrong");
   a_wipe_confirm: assert property (go_r && cyc_write && op_r == OP_SECTOR_WIPE && step_r == 3'd5
      |-> cyc_addr == addr_r && cyc_wdata == CODE_BLOCK_CONF)
      else $error("sector wipe confirm wrong");
   a_poll_quiet: assert property (state_r == S_POLL |-> o_write_n)
      else $error("write strobe during polling");
   a_flags_masked: assert property ((flags_r & ~STATUS_MASK) == 8'h00)
      else $error("reserved status bits kept");
   a_poll_addr: assert property (go_r && state_r == S_POLL |-> cyc_addr == addr_r)
      else $error("poll not at target address");
   a_toggle_done: assert property (i_ce && state_r == S_POLL && cyc_done && !first_r && toggle_same
      |=> state_r == S_FINAL)
      else $error("equal toggle reads did not end polling");

   c_prog_done: cover property (op_r == OP_WORD_WRITE && $fell(busy_r) && !err_r);
   c_wipe_done: cover property (op_r == OP_SECTOR_WIPE && $fell(busy_r));
   c_error_seen: cover property ($rose(err_r));
   c_signature: cover property (op_r == OP_SIGNATURE && $fell(busy_r));
endmodule

// *** sim/flash_dev_model.sv ***
// Behavioural word-wide flash: coded write cycles, array, signature and status reads.
// Assumes the host keeps address and data steady around each strobe edge.
`timescale 1ns/1ps
module flash_dev_model
   import flash_host_pkg::*;
#(
   parameter logic [15:0] MFR_CODE = 16'h0011, // Arbitrary value
   parameter logic [15:0] DEV_CODE = 16'h0022, // Arbitrary value
   parameter int BUSY_READS = 5
) (
   // Bus pins
   input wire logic i_chip_sel_n,
   input wire logic i_out_en_n,
   input wire logic i_write_n,
   input wire logic [flash_host_pkg::ADDR_W-1:0] i_addr,
   input wire logic [flash_host_pkg::DATA_W-1:0] i_dq,
   output logic [flash_host_pkg::DATA_W-1:0] o_dq,
   output logic o_ready_busy,
   // Fault injection and counts
   input wire logic i_fail,
   input wire logic i_protect,
   output logic [7:0] o_wr_count
);
   logic [15:0] mem [int];
   logic [15:0] last_r = 16'h0000;
   logic [15:0] pend_r = 16'h0000;
   logic [ADDR_W-1:0] tgt_r = '0;
   int step_r = 0;
   int left_r = 0;
   logic sig_r = 0, busy_r = 0, prog_r = 0, chip_r = 0, fail_r = 0, tog_r = 0, sus_r = 0, prot_r = 0;
   logic [ADDR_W-1:0] etgt_r = '0;
   logic [7:0] wr_r = 8'h00;
   int kill_q[$];

   task automatic begin_op(input logic prog);
      prog_r = prog;
      tgt_r = i_addr;
      busy_r = 1'b1;
      left_r = BUSY_READS;
      fail_r = i_fail;
      prot_r = i_protect && !prog;
      tog_r = 1'b0;
   endtask

   task automatic finish_op();
      kill_q.delete();
      busy_r = 1'b0;
      if (prog_r) mem[int'(tgt_r)] = pend_r & (mem.exists(int'(tgt_r)) ? mem[int'(tgt_r)] : 16'hffff);
      else if (!prot_r) begin
         foreach (mem[k]) if (chip_r || k[18:12] == tgt_r[18:12]) kill_q.push_back(k);
      end
      foreach (kill_q[i]) mem.delete(kill_q[i]);
   endtask

   always @(posedge i_write_n) begin
      if (i_chip_sel_n === 1'b0) begin
         wr_r = wr_r + 8'h01;
         sig_r = 1'b0;
         if (i_dq == CODE_READ_ARRAY) begin
            busy_r = 1'b0;
            fail_r = 1'b0;
         end
         if (step_r == 3) begin
            pend_r = i_dq;
            begin_op(1'b1);
            step_r = 0;
         end else if (step_r == 6) begin
            chip_r = (i_dq == CODE_CHIP_CONF);
            if (i_dq == CODE_BLOCK_CONF || chip_r) begin_op(1'b0);
            step_r = 0;
         end else if (i_addr == UNLOCK_ADDR1 && i_dq == CODE_UNLOCK1 && (step_r == 0 || step_r == 4)) begin
            step_r = step_r + 1;
         end else if (i_addr == UNLOCK_ADDR2 && i_dq == CODE_UNLOCK2 && (step_r == 1 || step_r == 5)) begin
            step_r = step_r + 1;
         end else if (step_r == 2 && i_addr == UNLOCK_ADDR1) begin
            sig_r = (i_dq == CODE_SIGNATURE);
            step_r = (i_dq == CODE_PROGRAM) ? 3 : (i_dq == CODE_SETUP_ERASE) ? 4 : 0;
         end else if (busy_r && !prog_r && i_dq == CODE_PAUSE) begin
            sus_r = 1'b1;
            busy_r = 1'b0;
            etgt_r = tgt_r;
         end else if (sus_r && i_dq == CODE_BLOCK_CONF) begin
            // Fault input sampled again, so a failed erase can be paused and then completed
            sus_r = 1'b0;
            begin_op(1'b0);
         end else step_r = 0;
      end
   end

   // Reserved status bits read as 1 so that a host which fails to mask them is caught
   always @(negedge i_out_en_n) begin
      if (i_chip_sel_n === 1'b0) begin
         if (busy_r) begin
            tog_r = ~tog_r;
            last_r = {8'h00, prog_r ? ~pend_r[7] : 1'b0, tog_r, fail_r, 1'b1, ~prog_r, tog_r, 2'b11};
            if (!fail_r) left_r = left_r - 1;
            if (left_r == 0) finish_op();
         end else if (sus_r && i_addr[18:12] == etgt_r[18:12]) last_r = 16'h00ff;
         else if (sig_r) last_r = i_addr[0] ? DEV_CODE : MFR_CODE;
         else last_r = mem.exists(int'(i_addr)) ? mem[int'(i_addr)] : 16'hffff;
      end
   end

   // Released data lines show the inverse of the last word, never a stale copy
   assign o_dq = (i_chip_sel_n === 1'b0 && i_out_en_n === 1'b0) ? last_r : ~last_r;
   assign o_ready_busy = ~busy_r;
   assign o_wr_count = wr_r;
endmodule

// *** sim/flash_host_ctrl_tb.sv ***
// Self-checking bench for the flash host controller against the flash model.
// Assumes the software port answers reads in the following cycle.
`timescale 1ns/1ps
module flash_host_ctrl_tb;
   import flash_host_pkg::*;
   logic i_mclk = 1'b0;
   logic i_resetn = 1'b0;
   logic [2:0] i_reg_addr = 3'h0;
   logic [31:0] i_reg_wdata = 32'h0;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic fail = 1'b0;
   logic protect = 1'b0;
   logic ce = 1'b1;
   logic [31:0] o_reg_rdata;
   logic o_chip_sel_n, o_out_en_n, o_write_n, o_dq_oe_n, ready_busy;
   logic [ADDR_W-1:0] o_addr;
   logic [DATA_W-1:0] o_dq, dev_dq, dq_wire;
   logic [7:0] wr_count;
   logic [18:0] addrs [6];
   logic [15:0] datas [6];
   logic [15:0] rd;
   logic [31:0] st;
   int errors = 0;
   int checks_done = 0;
   int seed = 77;

   assign dq_wire = (o_dq_oe_n === 1'b0) ? o_dq : dev_dq;
   always #12.5 i_mclk = ~i_mclk;

   flash_host_ctrl u_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(ce), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
      .o_chip_sel_n(o_chip_sel_n), .o_out_en_n(o_out_en_n), .o_write_n(o_write_n), .o_addr(o_addr),
      .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n), .i_dq(dq_wire), .i_ready_busy(ready_busy));

   flash_dev_model u_dev (.i_chip_sel_n(o_chip_sel_n), .i_out_en_n(o_out_en_n), .i_write_n(o_write_n),
      .i_addr(o_addr), .i_dq(dq_wire), .o_dq(dev_dq), .o_ready_busy(ready_busy), .i_fail(fail),
      .i_protect(protect),
      .o_wr_count(wr_count));

   function automatic logic [7:0] exp_writes(input op_type op);
      case (op)
         OP_READ_ARRAY, OP_WIPE_PAUSE, OP_WIPE_CONTINUE: return 8'h01;
         OP_SIGNATURE: return 8'h03;
         OP_WORD_WRITE: return 8'h04;
         OP_SECTOR_WIPE, OP_CHIP_WIPE: return 8'h06;
         default: return 8'h00;
      endcase
   endfunction

   task automatic conclude();
      $display("Counts: %0d checks, %0d errors", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_mclk);
      i_reg_wr <= 1'b0;
      @(posedge i_mclk);
   endtask

   task automatic reg_rd(input logic [2:0] a, output logic [31:0] d);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_mclk);
      i_reg_rd <= 1'b0;
      #1 d = o_reg_rdata;
      @(posedge i_mclk);
   endtask

   task automatic do_op(input op_type op, input logic [18:0] a, input logic [15:0] d, input logic ferr,
                        output logic [15:0] rdw);
      int n;
      logic [7:0] w0;
      logic [31:0] r;
      n = 0;
      w0 = wr_count;
      reg_wr(REG_ADDR, {13'h0, a});
      reg_wr(REG_DATA, {16'h0, d});
      reg_wr(REG_CMD, {29'h0, op});
      do begin
         reg_rd(REG_STATUS, st);
         n++;
      end while (st[ST_BUSY] !== 1'b0 && n < 3000);
      if (n >= 3000) begin
         errors++;
         conclude();
      end
      check(32'(wr_count - w0), 32'(exp_writes(op)));
      check(32'(st[ST_ERROR]), 32'(ferr));
      check(32'(st[ST_DONE]), 32'h1);
      check(st & 32'h0000_1300, 32'h0);
      reg_rd(REG_RDATA, r);
      rdw = r[15:0];
   endtask

   initial begin
      repeat (16) @(posedge i_mclk);
      check({28'h0, o_chip_sel_n, o_out_en_n, o_write_n, o_dq_oe_n}, 32'hf);
      check(o_reg_rdata, 32'h0);
      i_resetn <= 1'b1;
      @(posedge i_mclk);
      for (int i = 0; i < 6; i++) begin
         addrs[i] = {7'(i + 1), 12'($random(seed))};
         datas[i] = 16'($random(seed));
         do_op(OP_WORD_WRITE, addrs[i], datas[i], 1'b0, rd);
         check(32'(rd), 32'(datas[i]));
      end
      for (int i = 0; i < 6; i++) begin
         do_op(OP_READ, addrs[i], 16'h0, 1'b0, rd);
         check(32'(rd), 32'(datas[i]));
      end
      $display("test program done");
      do_op(OP_SIGNATURE, 19'h0, 16'h0, 1'b0, rd);
      check(32'(rd), 32'(u_dev.MFR_CODE));
      do_op(OP_SIGNATURE, 19'h1, 16'h0, 1'b0, rd);
      check(32'(rd), 32'(u_dev.DEV_CODE));
      do_op(OP_READ_ARRAY, 19'h0, 16'h0, 1'b0, rd);
      do_op(OP_READ, addrs[0], 16'h0, 1'b0, rd);
      check(32'(rd), 32'(datas[0]));
      $display("test signature done");
      do_op(OP_SECTOR_WIPE, addrs[1], 16'h0, 1'b0, rd);
      check(32'(rd), 32'hffff);
      for (int i = 0; i < 6; i++) begin
         do_op(OP_READ, addrs[i], 16'h0, 1'b0, rd);
         check(32'(rd), (i == 1) ? 32'hffff : 32'(datas[i]));
      end
      protect <= 1'b1;
      do_op(OP_SECTOR_WIPE, addrs[5], 16'h0, 1'b0, rd);
      protect <= 1'b0;
      check(32'(rd), 32'(datas[5]));
      fail <= 1'b1;
      do_op(OP_SECTOR_WIPE, addrs[3], 16'h0, 1'b1, rd);
      fail <= 1'b0;
      do_op(OP_WIPE_PAUSE, addrs[3], 16'h0, 1'b0, rd);
      do_op(OP_READ, addrs[3], 16'h0, 1'b0, rd);
      check(32'(rd[7:6]), 32'h3);
      do_op(OP_READ, addrs[4], 16'h0, 1'b0, rd);
      check(32'(rd), 32'(datas[4]));
      do_op(OP_WORD_WRITE, addrs[0], datas[0], 1'b0, rd);
      check(32'(rd), 32'(datas[0]));
      do_op(OP_WIPE_CONTINUE, addrs[3], 16'h0, 1'b0, rd);
      check(32'(rd), 32'hffff);
      do_op(OP_CHIP_WIPE, 19'h0, 16'h0, 1'b0, rd);
      do_op(OP_READ, addrs[3], 16'h0, 1'b0, rd);
      check(32'(rd), 32'hffff);
      $display("test wipe done");
      fail <= 1'b1;
      do_op(OP_WORD_WRITE, addrs[2], 16'h1234, 1'b1, rd);
      fail <= 1'b0;
      do_op(OP_READ_ARRAY, 19'h0, 16'h0, 1'b0, rd);
      // Frozen by the enable: the address write must not land
      ce <= 1'b0;
      reg_wr(REG_ADDR, 32'h0000_1234);
      ce <= 1'b1;
      reg_rd(REG_ADDR, st);
      check(st, 32'h0);
      reg_rd(3'h5, st);
      check(st, 32'h0);
      $display("test failure done");
      conclude();
   end
endmodule
